// ===== pos_host_model.sv
// Purpose: Host controller model that selects a point and pulses the move trigger.
// Assumes: One request at a time; go_i is a one-cycle strobe.
// Notes:   The trigger is held for several cycles so the pin filter sees it.
`default_nettype none
module pos_host_model (
  // System
  input  wire logic       clk_i,
  // Request
  input  wire logic       go_i,
  input  wire logic [2:0] point_i,
  // Pins
  output logic      [2:0] point_select_o,
  output logic            trigger_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // The point lines settle well before the trigger edge, as a real host must.
  initial begin
    point_select_o = 3'h0;
    trigger_o = 1'b0;
    forever begin
      @(posedge clk_i iff go_i);
      #1 point_select_o = point_i;
      repeat (4) @(posedge clk_i);
      #1 trigger_o = 1'b1;
      repeat (6) @(posedge clk_i);
      #1 trigger_o = 1'b0;
    end
  end
endmodule // pos_host_model
`default_nettype wire

// ===== pos_ramp.sv
// Purpose: Speed ramp generator toward a target speed.
// Assumes: Step interval in 1000 ns units comes from the owner.
// Notes:   With ramping off the speed jumps straight to the target.
`default_nettype none
module pos_ramp (
  // System
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Control
  input  wire logic        ramp_en_i,
  input  wire logic [15:0] target_i,
  input  wire logic [15:0] accel_i,
  input  wire logic [15:0] decel_i,
  // Output
  output logic      [15:0] speed_o
);
  import pos_seq_pkg::*;
  logic [31:0] tick_reg;
  logic        up;
  logic [15:0] step_len;

  assign up       = target_i > speed_o;
  assign step_len = up ? accel_i : decel_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_o  <= 16'h0000;
      tick_reg <= 32'h0;
    end else if (!ramp_en_i) begin
      speed_o  <= target_i;
      tick_reg <= 32'h0;
    end else if (speed_o == target_i) begin
      tick_reg <= 32'h0;
    end else if (tick_reg >= (32'(step_len) * 32'(RAMP_UNIT_CYC))) begin
      tick_reg <= 32'h0;
      speed_o  <= up ? speed_o + 16'h0001 : speed_o - 16'h0001;
    end else begin
      tick_reg <= tick_reg + 32'h1;
    end
  end
endmodule // pos_ramp
`default_nettype wire

// ===== pos_seq_pkg.sv
// Purpose: Shared constants for the internal point positioning sequencer.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes:   Offsets are parameter addresses of the word-wide parameter port.
`default_nettype none
package pos_seq_pkg;
  localparam logic [15:0] ADDR_CTRL_MODE  = 16'h0101;
  localparam logic [15:0] ADDR_POS_INTERP = 16'h0121;
  localparam logic [15:0] ADDR_ACCEL      = 16'h0122;
  localparam logic [15:0] ADDR_DECEL      = 16'h0123;
  localparam logic [15:0] ADDR_SCURVE     = 16'h0124;
  localparam logic [15:0] ADDR_GEAR_NUM   = 16'h012c;
  localparam logic [15:0] ADDR_GEAR_DEN   = 16'h012d;
  localparam logic [15:0] ADDR_HOME_MODE  = 16'h012f;
  localparam logic [15:0] ADDR_HOME_ROT   = 16'h0132;
  localparam logic [15:0] ADDR_HOME_PLS   = 16'h0133;
  // Point targets: rotation at 0x010f+2n, pulses at 0x0110+2n; speeds 0x0224+n.
  localparam logic [15:0] ADDR_POINT_BASE = 16'h010f;
  localparam logic [15:0] ADDR_SPEED_BASE = 16'h0224;
  localparam logic [15:0] ADDR_ABORT_FN   = 16'h0232;
  localparam logic [15:0] ADDR_HOME_HI    = 16'h0130;
  localparam logic [15:0] ADDR_HOME_LO    = 16'h0131;
  localparam logic [15:0] ADDR_STATUS     = 16'h0300;
  localparam logic [15:0] MODE_FWD_PR     = 16'h0001;
  localparam logic [15:0] MODE_REV_PR     = 16'h0101;
  localparam logic [15:0] HOME_AUTO_FWD   = 16'd100;
  localparam logic [15:0] HOME_SIG_FWD    = 16'd202;
  localparam logic [15:0] HOME_SIG_REV    = 16'd203;
  localparam logic [15:0] ABORT_ENABLED   = 16'd2;
  localparam int          PULSES_PER_REV  = 10000;
  localparam int          RAMP_UNIT_NS    = 1000;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          RAMP_UNIT_CYC   = RAMP_UNIT_NS / CLK_PERIOD_NS;
  localparam int          POS_W           = 32;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_HOME = 3'b001, ST_RUN = 3'b011, ST_STOP = 3'b010, ST_ESTOP = 3'b110
  } seq_state_e;
endpackage : pos_seq_pkg
`default_nettype wire

// ===== pos_seq_top.sv
// Purpose: Internal point positioning sequencer with homing, hold and abort.
// Assumes: Digital inputs are asynchronous pins; parameters come over a word port.
// Notes:   Motion is a pulse accumulator; one pulse per speed-scaled interval.
// Behaviour
// - Absolute or incremental target per interpretation setting
// - S-curve zero disables ramping and times
// - Homing offset equals rotations times 10000 plus pulses
// - Settings 202/203 home forward/reverse on op-select low
// - Mode 001 forward, 101 reverse direction
// - Eight points, each target pair plus speed
// - Hold decelerates; next trigger finishes remaining pulses
// - Abort setting 2 discards remainder on abort
// - Position scaled by gear numerator over denominator
// - Trigger starts move to selected point
// - Setting 100 homes on servo-on; positioning after
// - Ready, target reached, home done outputs
// - Normally-closed inhibits block motion per direction
// - Homing uses high and low speeds
// - Pulse plus direction input; clear input zeroes count
// - Both op-selects on raise e-stop warning
`default_nettype none
module pos_seq_top #(
  parameter int NPOINTS = 8
) (
  // System
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Parameter port
  input  wire logic        par_wr_i,
  input  wire logic [15:0] par_addr_i,
  input  wire logic [15:0] par_wdata_i,
  output logic      [15:0] par_rdata_o,
  // Digital inputs
  input  wire logic        servo_enable_in_i,
  input  wire logic        command_trigger_in_i,
  input  wire logic        hold_in_i,
  input  wire logic        abort_clear_in_i,
  input  wire logic [2:0]  point_select_i,
  input  wire logic        op_select_low_i,
  input  wire logic        op_select_high_i,
  input  wire logic        origin_sensor_in_i,
  input  wire logic        homing_start_in_i,
  input  wire logic        forward_inhibit_in_i,
  input  wire logic        reverse_inhibit_in_i,
  input  wire logic        ext_pulse_mode_i,
  input  wire logic        ext_pulse_i,
  input  wire logic        ext_dir_i,
  input  wire logic        pulse_clear_i,
  // Status and motion
  output logic             drive_ready_out_o,
  output logic             target_reached_out_o,
  output logic             home_done_o,
  output logic             estop_warn_o,
  output logic             step_o,
  output logic             dir_o,
  output logic signed [31:0] position_o
);
  import pos_seq_pkg::*;

  localparam int NIN = 15;
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] lvl;
  logic [NIN-1:0] rise;

  assign pin_raw = {servo_enable_in_i, command_trigger_in_i, hold_in_i, abort_clear_in_i,
                    point_select_i, op_select_low_i, op_select_high_i, origin_sensor_in_i,
                    homing_start_in_i, forward_inhibit_in_i, reverse_inhibit_in_i,
                    ext_pulse_i, pulse_clear_i};

  for (genvar g = 0; g < NIN; g++) begin : g_sync
    pos_sync u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (pin_raw[g]),
      .level_o (lvl[g]),
      .rise_o  (rise[g])
    );
  end

  logic       servo_enable_in;
  logic       move_trigger_in_rise;
  logic       hold_lv;
  logic       abort_rise;
  logic [2:0] psel;
  logic       md0;
  logic       md1;
  logic       org_rise;
  logic       homing_start_in_rise;
  logic       fwd_ok;
  logic       rev_ok;
  logic       epls_rise;
  logic       pclr;
  logic       edir_meta;
  logic       edir_reg;
  logic       emode_meta;
  logic       emode_reg;

  assign servo_enable_in        = lvl[14];
  assign move_trigger_in_rise  = rise[13];
  assign hold_lv    = lvl[12];
  assign abort_rise = rise[11];
  assign psel       = lvl[10:8];
  assign md0        = lvl[7];
  assign md1        = lvl[6];
  assign org_rise   = rise[5];
  assign homing_start_in_rise  = rise[4];
  assign fwd_ok     = lvl[3];
  assign rev_ok     = lvl[2];
  assign epls_rise  = rise[1];
  assign pclr       = lvl[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edir_meta  <= 1'b0;
      edir_reg   <= 1'b0;
      emode_meta <= 1'b0;
      emode_reg  <= 1'b0;
    end else begin
      edir_meta  <= ext_dir_i;
      edir_reg   <= edir_meta;
      emode_meta <= ext_pulse_mode_i;
      emode_reg  <= emode_meta;
    end
  end

  // Parameter storage.
  logic [15:0] ctrl_mode_reg;
  logic [15:0] interp_reg;
  logic [15:0] accel_reg;
  logic [15:0] decel_reg;
  logic [15:0] scurve_reg;
  logic [15:0] gear_num_reg;
  logic [15:0] gear_den_reg;
  logic [15:0] home_mode_reg;
  logic [15:0] home_rot_reg;
  logic [15:0] home_pls_reg;
  logic [15:0] abort_fn_reg;
  logic [15:0] home_hi_reg;
  logic [15:0] home_lo_reg;
  logic [15:0] pt_rot_reg [NPOINTS];
  logic [15:0] pt_pls_reg [NPOINTS];
  logic [15:0] pt_spd_reg [NPOINTS];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_mode_reg <= MODE_FWD_PR;
      interp_reg    <= 16'h0000;
      accel_reg     <= 16'h0000;
      decel_reg     <= 16'h0000;
      scurve_reg    <= 16'h0000;
      gear_num_reg  <= 16'h0001;
      gear_den_reg  <= 16'h0001;
      home_mode_reg <= 16'h0000;
      home_rot_reg  <= 16'h0000;
      home_pls_reg  <= 16'h0000;
      abort_fn_reg  <= 16'h0000;
      home_hi_reg   <= 16'h0000;
      home_lo_reg   <= 16'h0000;
      for (int i = 0; i < NPOINTS; i++) begin
        pt_rot_reg[i] <= 16'h0000;
        pt_pls_reg[i] <= 16'h0000;
        pt_spd_reg[i] <= 16'h0000;
      end
    end else if (par_wr_i) begin
      case (par_addr_i)
        ADDR_CTRL_MODE:  ctrl_mode_reg <= par_wdata_i;
        ADDR_POS_INTERP: interp_reg    <= par_wdata_i;
        ADDR_ACCEL:      accel_reg     <= par_wdata_i;
        ADDR_DECEL:      decel_reg     <= par_wdata_i;
        ADDR_SCURVE:     scurve_reg    <= par_wdata_i;
        ADDR_GEAR_NUM:   gear_num_reg  <= par_wdata_i;
        ADDR_GEAR_DEN:   gear_den_reg  <= par_wdata_i;
        ADDR_HOME_MODE:  home_mode_reg <= par_wdata_i;
        ADDR_HOME_ROT:   home_rot_reg  <= par_wdata_i;
        ADDR_HOME_PLS:   home_pls_reg  <= par_wdata_i;
        ADDR_ABORT_FN:   abort_fn_reg  <= par_wdata_i;
        ADDR_HOME_HI:    home_hi_reg   <= par_wdata_i;
        ADDR_HOME_LO:    home_lo_reg   <= par_wdata_i;
        default: begin
          for (int i = 0; i < NPOINTS; i++) begin
            if (par_addr_i == ADDR_POINT_BASE + 16'(2 * i)) pt_rot_reg[i] <= par_wdata_i;
            if (par_addr_i == ADDR_POINT_BASE + 16'(2 * i + 1)) pt_pls_reg[i] <= par_wdata_i;
            if (par_addr_i == ADDR_SPEED_BASE + 16'(i)) pt_spd_reg[i] <= par_wdata_i;
          end
        end
      endcase
    end
  end

  // Sequencer state.
  seq_state_e          state_reg;
  logic signed [31:0]  cmd_pos_reg;
  logic signed [31:0]  target_reg;
  logic        [15:0]  run_speed_reg;
  logic                homed_reg;
  logic                done_reg;
  logic                home_fast_reg;
  logic                home_dir_reg;
  logic        [31:0]  pace_reg;
  logic signed [31:0]  ext_count_reg;

  logic               ramp_en;
  logic        [15:0] speed;
  logic        [15:0] speed_goal;
  logic signed [31:0] point_abs;
  logic signed [31:0] home_offset;
  logic signed [31:0] remain;
  logic               move_fwd;
  logic               blocked;
  logic               pulse_due;
  logic               estop;
  logic               home_sig_mode;

  assign ramp_en     = scurve_reg != 16'h0000;
  assign home_offset = $signed(32'(home_rot_reg)) * 32'(PULSES_PER_REV) + $signed(32'(home_pls_reg));
  assign point_abs   = $signed(32'(pt_rot_reg[psel])) * 32'(PULSES_PER_REV) + $signed(32'(pt_pls_reg[psel]));
  assign remain      = target_reg - cmd_pos_reg;
  // Count direction follows the remainder sign, or the home direction; mode 101 only inverts dir_o.
  assign move_fwd    = (state_reg == ST_HOME) ? home_dir_reg : (remain > 0);
  assign blocked     = move_fwd ? !fwd_ok : !rev_ok;
  assign estop       = md0 & md1;
  assign home_sig_mode = !md1 && md0 && (home_mode_reg == HOME_SIG_FWD || home_mode_reg == HOME_SIG_REV);

  always_comb begin
    case (state_reg)
      ST_RUN:  speed_goal = blocked ? 16'h0000 : run_speed_reg;
      ST_HOME: speed_goal = blocked ? 16'h0000 : (home_fast_reg ? home_hi_reg : home_lo_reg);
      default: speed_goal = 16'h0000;
    endcase
  end

  pos_ramp u_ramp (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ramp_en_i (ramp_en),
    .target_i  (speed_goal),
    .accel_i   (accel_reg),
    .decel_i   (decel_reg),
    .speed_o   (speed)
  );

  // Pulse pacing: interval shrinks as speed rises.
  assign pulse_due = (speed != 16'h0000) && (pace_reg >= (32'hffff / 32'(speed)));

  always_ff @(posedge clk_i) begin
    if (rst_i || !pulse_due && speed == 16'h0000) begin
      pace_reg <= 32'h0;
    end else if (pulse_due) begin
      pace_reg <= 32'h0;
    end else begin
      pace_reg <= pace_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg     <= ST_IDLE;
      cmd_pos_reg   <= 32'sh0;
      target_reg    <= 32'sh0;
      run_speed_reg <= 16'h0000;
      homed_reg     <= 1'b0;
      done_reg      <= 1'b0;
      home_fast_reg <= 1'b0;
      home_dir_reg  <= 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (estop) begin
            state_reg <= ST_ESTOP;
          end else if (servo_enable_in && !homed_reg && (home_mode_reg == HOME_AUTO_FWD || (home_sig_mode && homing_start_in_rise))) begin
            state_reg     <= ST_HOME;
            home_dir_reg  <= home_mode_reg != HOME_SIG_REV;
            home_fast_reg <= 1'b1;
            done_reg      <= 1'b0;
          end else if (servo_enable_in && move_trigger_in_rise && !emode_reg && (homed_reg || home_mode_reg == 16'h0000)) begin
            // A trigger after a hold resumes the stored target; otherwise load the point.
            if (remain == 0 || done_reg) begin
              target_reg <= (interp_reg == 16'h0001) ? cmd_pos_reg + point_abs : point_abs;
            end
            run_speed_reg <= pt_spd_reg[psel];
            done_reg      <= 1'b0;
            state_reg     <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (estop || !servo_enable_in) begin
            state_reg <= ST_STOP;
          end else if (hold_lv) begin
            state_reg <= ST_STOP;
          end else if (abort_rise && abort_fn_reg == ABORT_ENABLED) begin
            state_reg <= ST_STOP;
            done_reg  <= 1'b1;
          end else if (remain == 0) begin
            done_reg  <= 1'b1;
            state_reg <= ST_IDLE;
          end
          if (pulse_due && remain != 0 && !blocked) begin
            cmd_pos_reg <= move_fwd ? cmd_pos_reg + 32'sd1 : cmd_pos_reg - 32'sd1;
          end
        end
        ST_HOME: begin
          if (estop || !servo_enable_in) begin
            state_reg <= ST_STOP;
          end else if (org_rise && home_fast_reg) begin
            home_fast_reg <= 1'b0;
          end else if (org_rise || (!home_fast_reg && blocked)) begin
            cmd_pos_reg <= home_offset;
            target_reg  <= home_offset;
            homed_reg   <= 1'b1;
            state_reg   <= ST_STOP;
          end
          if (pulse_due && !blocked) begin
            cmd_pos_reg <= home_dir_reg ? cmd_pos_reg + 32'sd1 : cmd_pos_reg - 32'sd1;
          end
        end
        ST_STOP: begin
          if (speed == 16'h0000) begin
            state_reg <= estop ? ST_ESTOP : ST_IDLE;
            // An aborted move is not a completed one, so the flag drops once the remainder is gone.
            if (done_reg) begin
              target_reg <= cmd_pos_reg;
              done_reg   <= 1'b0;
            end
          end else if (pulse_due && !blocked && remain != 0) begin
            cmd_pos_reg <= move_fwd ? cmd_pos_reg + 32'sd1 : cmd_pos_reg - 32'sd1;
          end
        end
        ST_ESTOP: begin
          if (!md0 && !md1) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // External pulse count, pulse plus direction.
  always_ff @(posedge clk_i) begin
    if (rst_i || pclr) begin
      ext_count_reg <= 32'sh0;
    end else if (emode_reg && epls_rise) begin
      ext_count_reg <= edir_reg ? ext_count_reg - 32'sd1 : ext_count_reg + 32'sd1;
    end
  end

  // Outputs.
  logic signed [47:0] geared;
  assign geared = (48'(ext_mux()) * $signed({32'h0, gear_num_reg})) / $signed({32'h0, gear_den_reg | 16'h0000});

  function automatic logic signed [47:0] ext_mux();
    ext_mux = emode_reg ? 48'(ext_count_reg) : 48'(cmd_pos_reg);
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_ready_out_o    <= 1'b0;
      target_reached_out_o <= 1'b0;
      home_done_o          <= 1'b0;
      estop_warn_o         <= 1'b0;
      step_o               <= 1'b0;
      dir_o                <= 1'b0;
      position_o           <= 32'sh0;
    end else begin
      drive_ready_out_o    <= !estop;
      target_reached_out_o <= done_reg && (state_reg == ST_IDLE || state_reg == ST_ESTOP);
      home_done_o          <= homed_reg;
      estop_warn_o         <= estop;
      // A step is shown only when the position really moves, so a counter of steps tracks position.
      step_o               <= pulse_due && !blocked &&
                              (state_reg == ST_HOME || (state_reg != ST_IDLE && remain != 0));
      dir_o                <= move_fwd ^ (ctrl_mode_reg == MODE_REV_PR);
      position_o           <= (gear_den_reg == 16'h0000) ? 32'(ext_mux()) : 32'(geared);
    end
  end

  always_comb begin
    par_rdata_o = 16'h0000;
    case (par_addr_i)
      ADDR_CTRL_MODE:  par_rdata_o = ctrl_mode_reg;
      ADDR_POS_INTERP: par_rdata_o = interp_reg;
      ADDR_ACCEL:      par_rdata_o = accel_reg;
      ADDR_DECEL:      par_rdata_o = decel_reg;
      ADDR_SCURVE:     par_rdata_o = scurve_reg;
      ADDR_GEAR_NUM:   par_rdata_o = gear_num_reg;
      ADDR_GEAR_DEN:   par_rdata_o = gear_den_reg;
      ADDR_HOME_MODE:  par_rdata_o = home_mode_reg;
      ADDR_HOME_ROT:   par_rdata_o = home_rot_reg;
      ADDR_HOME_PLS:   par_rdata_o = home_pls_reg;
      ADDR_ABORT_FN:   par_rdata_o = abort_fn_reg;
      ADDR_HOME_HI:    par_rdata_o = home_hi_reg;
      ADDR_HOME_LO:    par_rdata_o = home_lo_reg;
      ADDR_STATUS:     par_rdata_o = {11'h000, state_reg, homed_reg, done_reg};
      default: begin
        for (int i = 0; i < NPOINTS; i++) begin
          if (par_addr_i == ADDR_POINT_BASE + 16'(2 * i)) par_rdata_o = pt_rot_reg[i];
          if (par_addr_i == ADDR_POINT_BASE + 16'(2 * i + 1)) par_rdata_o = pt_pls_reg[i];
          if (par_addr_i == ADDR_SPEED_BASE + 16'(i)) par_rdata_o = pt_spd_reg[i];
        end
      end
    endcase
  end

  a_ramp_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !ramp_en |=> speed == $past(speed_goal)) else $error("ramp not bypassed");
  a_estop_warn: assert property (@(posedge clk_i) disable iff (rst_i)
    estop |=> estop_warn_o) else $error("estop warning missing");
  a_home_done: assert property (@(posedge clk_i) disable iff (rst_i)
    homed_reg |=> home_done_o) else $error("home done not shown");
  a_fwd_inhibit: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_RUN && move_fwd && !fwd_ok) |=> $stable(cmd_pos_reg) || $past(state_reg) != ST_RUN)
    else $error("moved into forward limit");
  a_hold_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_RUN && hold_lv && !estop && servo_enable_in) |=> state_reg == ST_STOP) else $error("hold ignored");
  a_abort_done: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_STOP && done_reg && speed == 16'h0000) |=> target_reg == $past(cmd_pos_reg))
    else $error("abort kept remainder");
  a_move_trigger_in_run: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_IDLE && move_trigger_in_rise && servo_enable_in && !estop && !emode_reg &&
     (homed_reg || home_mode_reg == 16'h0000)) |=> state_reg == ST_RUN)
    else $error("trigger did not start move");
  a_pulse_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    pclr |=> ext_count_reg == 32'sh0) else $error("pulse clear failed");
endmodule // pos_seq_top
`default_nettype wire

// ===== pos_sync.sv
// Purpose: Two-flop synchroniser with rising-edge pulse for one pin.
// Assumes: Pin is asynchronous to clk_i.
// Notes:   The first flop feeds only the second flop.
`default_nettype none
module pos_sync (
  // System
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~prev_reg;
endmodule // pos_sync
`default_nettype wire

// ===== test_internal_point_positioning_sequencer.sv
// Purpose: Self-checking bench for the point positioning sequencer.
// Assumes: Homing mode stays 0, so moves need no homing; gear is 1/1 until the external count check sets 3/1.
// Notes:   Moves are judged when the target-reached flag rises.
`default_nettype none
module test_internal_point_positioning_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import pos_seq_pkg::*;
  logic clk_i, rst_i, par_wr_i, srv, hold, abrt, opl, oph, fin, rin, xd, xm, xp, pc, go, tr_q, move_trigger_in;
  logic drive_ready_out_o, target_reached_out_o, home_done_o, estop_warn_o, step_o, dir_o;
  logic [15:0] par_addr_i, par_wdata_i, par_rdata_o;
  logic [2:0] gpt, psel;
  logic [15:0] pls [8];
  logic signed [31:0] position_o, cur;
  logic signed [31:0] exp_q [$];
  int errors, total_checks, seed, k, steps, s0;
  pos_seq_top #(.NPOINTS(8)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .par_wr_i(par_wr_i), .par_addr_i(par_addr_i),
    .par_wdata_i(par_wdata_i), .par_rdata_o(par_rdata_o), .servo_enable_in_i(srv),
    .command_trigger_in_i(move_trigger_in), .hold_in_i(hold), .abort_clear_in_i(abrt), .point_select_i(psel),
    .op_select_low_i(opl), .op_select_high_i(oph), .origin_sensor_in_i(1'b0), .homing_start_in_i(1'b0),
    .forward_inhibit_in_i(fin), .reverse_inhibit_in_i(rin), .ext_pulse_mode_i(xm), .ext_pulse_i(xp),
    .ext_dir_i(xd), .pulse_clear_i(pc), .drive_ready_out_o(drive_ready_out_o),
    .target_reached_out_o(target_reached_out_o), .home_done_o(home_done_o), .estop_warn_o(estop_warn_o),
    .step_o(step_o), .dir_o(dir_o), .position_o(position_o));
  pos_host_model host (.clk_i(clk_i), .go_i(go), .point_i(gpt), .point_select_o(psel), .trigger_o(move_trigger_in));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1 par_wr_i = 1'b1;
    par_addr_i = a;
    par_wdata_i = d;
    @(posedge clk_i);
    #1 par_wr_i = 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk_i);
    #1 par_addr_i = a;
    #1 chk({16'h0, par_rdata_o}, {16'h0, e}, "read");
  endtask
  // The host model runs 10 cycles per request; 20 leaves margin.
  task automatic move(input logic [2:0] p);
    @(posedge clk_i);
    #1 gpt = p;
    go = 1'b1;
    @(posedge clk_i);
    #1 go = 1'b0;
    repeat (20) @(posedge clk_i);
  endtask
  task automatic settle;
    for (k = 0; k < 20000 && exp_q.size() > 0; k++) @(posedge clk_i);
    if (exp_q.size() > 0) begin
      errors++;
      $display("ERROR %0t move never completed", $time);
      exp_q.delete();
    end
  endtask
  // Any rise of the flag with no move expected is a move that should have been refused.
  always @(posedge clk_i) begin
    tr_q <= target_reached_out_o;
    if (step_o === 1'b1) steps <= steps + 1;
    if (!rst_i && target_reached_out_o === 1'b1 && tr_q === 1'b0) begin
      total_checks++;
      if (exp_q.size() == 0 || position_o !== exp_q[0]) begin
        errors++;
        $display("ERROR %0t stop at unexpected position %0d", $time, position_o);
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    close_out();
  end
  initial begin
    seed = 54151;
    {par_wr_i, srv, hold, abrt, opl, oph, go, xd, xm, xp, pc} = '0;
    {fin, rin} = 2'b11;
    {par_addr_i, par_wdata_i, gpt, errors, total_checks} = '0;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    #1 rst_i = 1'b0;
    rdc(ADDR_CTRL_MODE, 16'h0001);
    rdc(ADDR_GEAR_NUM, 16'h0001);
    rdc(ADDR_GEAR_DEN, 16'h0001);
    rdc(ADDR_SCURVE, 16'h0000);
    rdc(16'h0400, 16'h0000);
    move(3'h0);
    for (int n = 0; n < 8; n++) begin
      pls[n] = 16'(($random(seed) & 63) + 1);
      wr(ADDR_POINT_BASE + 16'(2 * n), 16'h0000);
      wr(ADDR_POINT_BASE + 16'(2 * n + 1), pls[n]);
      wr(ADDR_SPEED_BASE + 16'(n), 16'h2000);
      rdc(ADDR_POINT_BASE + 16'(2 * n + 1), pls[n]);
    end
    @(posedge clk_i);
    #1 srv = 1'b1;
    repeat (8) @(posedge clk_i);
    for (int n = 0; n < 8; n++) begin
      cur = (n == 0) ? 32'sd0 : 32'(pls[n - 1]);
      cur = (cur > 32'(pls[n])) ? cur - 32'(pls[n]) : 32'(pls[n]) - cur;
      s0 = steps;
      exp_q.push_back(32'(pls[n]));
      move(3'(n));
      settle();
      chk(steps - s0, cur, "step count");
    end
    cur = 32'(pls[7]);
    wr(ADDR_POS_INTERP, 16'h0001);
    for (int n = 0; n < 2; n++) begin
      cur = cur + 32'(pls[n]);
      exp_q.push_back(cur);
      move(3'(n));
      settle();
    end
    wr(ADDR_POINT_BASE + 16'h0001, 16'd600);
    exp_q.push_back(cur + 32'sd600);
    move(3'h0);
    #1 hold = 1'b1;
    repeat (50) @(posedge clk_i);
    #1 hold = 1'b0;
    move(3'h0);
    settle();
    wr(ADDR_ABORT_FN, ABORT_ENABLED);
    wr(ADDR_POS_INTERP, 16'h0000);
    wr(ADDR_POINT_BASE + 16'h0003, 16'd2000);
    move(3'h1);
    #1 abrt = 1'b1;
    repeat (8) @(posedge clk_i);
    #1 abrt = 1'b0;
    wr(ADDR_POINT_BASE + 16'h0003, 16'd9);
    exp_q.push_back(32'sd9);
    move(3'h1);
    settle();
    @(posedge clk_i);
    #1 {opl, oph} = 2'b11;
    repeat (6) @(posedge clk_i);
    #1 chk({31'h0, estop_warn_o}, 32'h1, "warning set");
    chk({31'h0, drive_ready_out_o}, 32'h0, "ready during stop");
    {opl, oph} = 2'b00;
    repeat (6) @(posedge clk_i);
    #1 chk({31'h0, estop_warn_o}, 32'h0, "warning clear");
    chk({31'h0, drive_ready_out_o}, 32'h1, "ready after stop");
    chk({31'h0, home_done_o}, 32'h0, "no homing run");
    fin = 1'b0;
    wr(ADDR_POINT_BASE + 16'h0005, 16'd300);
    move(3'h2);
    repeat (100) @(posedge clk_i);
    #1 chk(position_o, 32'h9, "inhibited move");
    chk({31'h0, step_o}, 32'h0, "step at limit");
    chk({31'h0, dir_o}, 32'h1, "forward sense");
    wr(ADDR_CTRL_MODE, MODE_REV_PR);
    repeat (2) @(posedge clk_i);
    #1 chk({31'h0, dir_o}, 32'h0, "reverse sense");
    // Five pulses up, two down, seen through a gear of 3/1.
    wr(ADDR_GEAR_NUM, 16'h0003);
    xm = 1'b1;
    for (int n = 0; n < 7; n++) begin
      repeat (3) @(posedge clk_i);
      #1 xp = 1'b1;
      repeat (3) @(posedge clk_i);
      #1 xp = 1'b0;
      xd = (n >= 4);
    end
    repeat (4) @(posedge clk_i);
    #1 chk(position_o, 32'h9, "geared count");
    pc = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 chk(position_o, 32'h0, "count cleared");
    close_out();
  end
endmodule // test_internal_point_positioning_sequencer
`default_nettype wire
